// [pkg/native_port_pkg.sv]
package native_port_pkg;
	// Request opcodes
	localparam logic [2:0] CMD_WRITE = 3'h0;
	localparam logic [2:0] CMD_READ = 3'h1;
	// Register map
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	// Control fields
	localparam int CTRL_REORDER_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Status fields
	localparam int STAT_MAINT_BIT = 0;
	localparam int STAT_ROW_OPEN_BIT = 1;
	localparam int STAT_RD_PEND_BIT = 2;
	localparam int STAT_WR_PEND_BIT = 3;
	// Timing of the modelled memory
	localparam real CLK_PERIOD_NS = 8.0;
	localparam real READ_LATENCY_NS = 40.0;
	localparam int READ_LAT_CYC = int'((READ_LATENCY_NS + CLK_PERIOD_NS - 1.0) / CLK_PERIOD_NS);
	localparam int MAINT_CYC = 4;
	localparam int PERIODIC_REFRESH_INTERVAL = 0;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// [core/dram_ctrl_native_port.sv]
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Accept flags prior-cycle strobed request as taken
// - Pointer echoed on write and read outputs
// - Precharge select 0 keeps the row open
// - Precharge select 1 closes row per request
// - Payload width is two times ratio times payload_bits
// - Write pointer shown at write column command
// - Only bytes with low mask are written
// - Write strobe marks buffer fetch, location freed
// - Read valid marks each valid read cycle
// - Read pointer captured at accept, returned
// - Last-transfer output held at one
// - User refresh: one refresh per rank
// - User calibration: one short ZQ per rank
// - Simultaneous refresh and calibration both issued
// - Refresh acknowledge pulses one cycle
// - Calibration acknowledge pulses one cycle
// - Opcode 000 write, 001 read, rest reserved
// - Reorder mode: data in processing order
module dram_ctrl_native_port
	import native_port_pkg::*;
#(
	parameter int clock_ratio = 4,
	parameter int payload_bits = 8,
	parameter int ptr_bits = 4,
	parameter int ranks = 1,
	parameter int mem_depth_bits = 6
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] request_cmd,
	input wire logic [mem_depth_bits-1:0] request_addr,
	input wire logic [ptr_bits-1:0] buffer_pointer_in,
	input wire logic auto_precharge_select,
	input wire logic request_valid,
	output logic accept,
	input wire logic [2*clock_ratio*payload_bits-1:0] write_payload_in,
	input wire logic [2*clock_ratio*payload_bits/8-1:0] write_byte_mask_in,
	output logic [ptr_bits-1:0] write_pointer_echo,
	output logic write_fetch_strobe,
	output logic [2*clock_ratio*payload_bits-1:0] read_payload_out,
	output logic [ptr_bits-1:0] read_pointer_echo,
	output logic read_valid_out,
	output logic read_last_transfer,
	input wire logic self_refresh_request,
	output logic self_refresh_active,
	input wire logic refresh_request,
	output logic refresh_done,
	input wire logic impedance_cal_request,
	output logic impedance_cal_done,
	output logic [ranks-1:0] refresh_cmd_issue,
	output logic [ranks-1:0] zq_short_cmd_issue,
	output logic precharge_cmd_issue,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int DW = 2*clock_ratio*payload_bits;
	localparam int BW = DW/8;
	localparam int LAT_W = $clog2(READ_LAT_CYC + 1);
	localparam int ROW_LSB = mem_depth_bits / 2;

	typedef enum logic [2:0]
	{
		M_IDLE = 3'b001,
		M_REF = 3'b010,
		M_ZQ = 3'b100
	} maint_t;

	logic [DW-1:0] mem_r [2**mem_depth_bits];

	// Sampled request fields, qualified by the strobe one cycle later
	logic [2:0] f_cmd_r;
	logic [mem_depth_bits-1:0] f_addr_r;
	logic [ptr_bits-1:0] f_ptr_r;
	logic f_ap_r;
	// One-entry slots: write and read proceed in parallel
	logic wr_pend_r, rd_pend_r;
	logic [mem_depth_bits-1:0] wr_addr_r, rd_addr_r;
	logic [ptr_bits-1:0] wr_ptr_r, rd_ptr_r;
	logic wr_ap_r, rd_ap_r;
	logic wr_data_due_r;
	logic [mem_depth_bits-1:0] wr_data_addr_r;
	logic [LAT_W-1:0] rd_cnt_r;
	logic [DW-1:0] rd_data_r;
	logic row_open_r;
	logic [mem_depth_bits-1:ROW_LSB] open_row_r;
	maint_t maint_r, maint_nxt;
	logic ref_pend_r, zq_pend_r;
	logic [3:0] maint_cnt_r;
	logic [31:0] ctrl_r;
	logic avs_pending_r;
	logic [31:0] wr_count_r;

	wire hold_traffic = ctrl_r[CTRL_HOLD_BIT] | (maint_r != M_IDLE) | ref_pend_r | zq_pend_r;
	wire legal_cmd = (f_cmd_r == CMD_WRITE) || (f_cmd_r == CMD_READ);
	wire slot_free = (f_cmd_r == CMD_WRITE) ? !wr_pend_r : !rd_pend_r;
	wire can_accept = legal_cmd && slot_free && !hold_traffic;
	wire take = request_valid && can_accept;
	// One write in flight at a time: the data address register is single
	wire write_go = wr_pend_r && !hold_traffic && !wr_data_due_r && !write_fetch_strobe;
	// Reorder off: a read waits until every earlier write has landed
	wire read_go = rd_pend_r && rd_cnt_r == '0 && !hold_traffic &&
		(ctrl_r[CTRL_REORDER_BIT] || (!wr_pend_r && !write_fetch_strobe && !wr_data_due_r));
	wire read_done = rd_pend_r && rd_cnt_r == LAT_W'(1);
	wire [mem_depth_bits-1:0] go_addr = write_go ? wr_addr_r : rd_addr_r;
	wire go_ap = write_go ? wr_ap_r : rd_ap_r;
	wire row_miss = row_open_r && open_row_r != go_addr[mem_depth_bits-1:ROW_LSB];
	wire col_go = write_go | read_go;
	wire maint_done = maint_r != M_IDLE && maint_cnt_r == 4'(MAINT_CYC - 1);
	wire avs_req = avs_read | avs_write;
	wire avs_hit_ctrl = avs_address == REG_CONTROL;
	wire [31:0] status_word = {28'h0, wr_pend_r, rd_pend_r, row_open_r, maint_r != M_IDLE};
	wire [31:0] avs_rd_mux = avs_hit_ctrl ? ctrl_r :
		(avs_address == REG_STATUS) ? status_word :
		(avs_address == REG_COUNT) ? wr_count_r : UNMAPPED_READ;

	function automatic logic [DW-1:0] merge_bytes(input logic [DW-1:0] old_d,
		input logic [DW-1:0] new_d, input logic [BW-1:0] mask);
		logic [DW-1:0] res;
		res = old_d;
		for (int i = 0; i < BW; i++)
		begin
			if (!mask[i])
			begin
				res[i*8 +: 8] = new_d[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_comb
	begin
		maint_nxt = maint_r;
		unique case (maint_r)
			M_IDLE:
			begin
				// Simultaneous requests run refresh first, then ZQ
				if (ref_pend_r && !wr_data_due_r && !write_fetch_strobe && !rd_pend_r)
					maint_nxt = M_REF;
				else if (zq_pend_r && !wr_data_due_r && !write_fetch_strobe && !rd_pend_r)
					maint_nxt = M_ZQ;
			end
			M_REF:
			begin
				if (maint_done)
					maint_nxt = M_IDLE;
			end
			M_ZQ:
			begin
				if (maint_done)
					maint_nxt = M_IDLE;
			end
			default:
			begin
				maint_nxt = M_IDLE;
			end
		endcase
	end

	// Request capture and slots
	always_ff @(posedge core_clk)
	begin
		f_cmd_r <= request_cmd;
		f_addr_r <= request_addr;
		f_ptr_r <= buffer_pointer_in;
		f_ap_r <= auto_precharge_select;
		if (reset)
		begin
			accept <= 1'b0;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= '0;
			rd_addr_r <= '0;
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			wr_ap_r <= 1'b0;
			rd_ap_r <= 1'b0;
		end
		else
		begin
			accept <= can_accept;
			if (take && f_cmd_r == CMD_WRITE)
			begin
				wr_pend_r <= 1'b1;
				wr_addr_r <= f_addr_r;
				wr_ptr_r <= f_ptr_r;
				wr_ap_r <= f_ap_r;
			end
			else if (write_go)
				wr_pend_r <= 1'b0;
			if (take && f_cmd_r == CMD_READ)
			begin
				rd_pend_r <= 1'b1;
				rd_addr_r <= f_addr_r;
				rd_ptr_r <= f_ptr_r;
				rd_ap_r <= f_ap_r;
			end
			else if (read_done)
				rd_pend_r <= 1'b0;
		end
	end

	// Column issue, row policy and data paths
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			write_fetch_strobe <= 1'b0;
			write_pointer_echo <= '0;
			wr_data_due_r <= 1'b0;
			wr_data_addr_r <= '0;
			read_valid_out <= 1'b0;
			read_pointer_echo <= '0;
			read_payload_out <= '0;
			rd_cnt_r <= '0;
			row_open_r <= 1'b0;
			open_row_r <= '0;
			precharge_cmd_issue <= 1'b0;
			wr_count_r <= '0;
		end
		else
		begin
			write_fetch_strobe <= write_go;
			wr_data_due_r <= write_fetch_strobe;
			precharge_cmd_issue <= col_go && row_miss;
			if (write_go)
			begin
				write_pointer_echo <= wr_ptr_r;
				wr_data_addr_r <= wr_addr_r;
			end
			if (wr_data_due_r)
			begin
				// Data is on the port the cycle after the echo
				mem_r[wr_data_addr_r] <= merge_bytes(mem_r[wr_data_addr_r],
					write_payload_in, write_byte_mask_in);
				wr_count_r <= wr_count_r + 32'h1;
			end
			if (read_go)
				rd_data_r <= mem_r[rd_addr_r];
			if (read_go)
				rd_cnt_r <= LAT_W'(READ_LAT_CYC);
			else if (rd_cnt_r != '0)
				rd_cnt_r <= rd_cnt_r - LAT_W'(1);
			read_valid_out <= read_done;
			if (read_done)
			begin
				read_payload_out <= rd_data_r;
				read_pointer_echo <= rd_ptr_r;
			end
			if (col_go)
			begin
				row_open_r <= !go_ap;
				open_row_r <= go_addr[mem_depth_bits-1:ROW_LSB];
			end
			else if (maint_r == M_IDLE && maint_nxt != M_IDLE)
				row_open_r <= 1'b0;
		end
	end

	// Maintenance sequencing; set wins over the clear at issue
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			maint_r <= M_IDLE;
			maint_cnt_r <= '0;
			ref_pend_r <= 1'b0;
			zq_pend_r <= 1'b0;
			refresh_done <= 1'b0;
			impedance_cal_done <= 1'b0;
			refresh_cmd_issue <= '0;
			zq_short_cmd_issue <= '0;
		end
		else
		begin
			maint_r <= maint_nxt;
			maint_cnt_r <= (maint_r != M_IDLE && !maint_done) ? maint_cnt_r + 4'h1 : 4'h0;
			refresh_cmd_issue <= {ranks{maint_r == M_IDLE && maint_nxt == M_REF}};
			zq_short_cmd_issue <= {ranks{maint_r == M_IDLE && maint_nxt == M_ZQ}};
			refresh_done <= maint_r == M_REF && maint_done;
			impedance_cal_done <= maint_r == M_ZQ && maint_done;
			if (refresh_request)
				ref_pend_r <= 1'b1;
			else if (maint_r == M_IDLE && maint_nxt == M_REF)
				ref_pend_r <= 1'b0;
			if (impedance_cal_request)
				zq_pend_r <= 1'b1;
			else if (maint_r == M_IDLE && maint_nxt == M_ZQ)
				zq_pend_r <= 1'b0;
		end
	end

	// Avalon-MM slave, answers one cycle after the request
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrl_r <= CTRL_RESET;
			avs_pending_r <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			read_last_transfer <= 1'b1;
			self_refresh_active <= 1'b0;
		end
		else
		begin
			read_last_transfer <= 1'b1;
			self_refresh_active <= 1'b0;
			avs_pending_r <= avs_req && avs_waitrequest && !avs_pending_r;
			avs_waitrequest <= !(avs_req && avs_waitrequest && !avs_pending_r);
			if (avs_req && avs_waitrequest && !avs_pending_r)
			begin
				avs_readdata <= avs_read ? avs_rd_mux : avs_readdata;
				if (avs_write && avs_hit_ctrl)
					ctrl_r <= {30'h0, avs_writedata[CTRL_HOLD_BIT], avs_writedata[CTRL_REORDER_BIT]};
			end
		end
	end
endmodule // dram_ctrl_native_port

// [tb/dram_ctrl_native_port_assertions.sv]
`timescale 1ns/1ps
module dram_ctrl_native_port_assertions
	import native_port_pkg::*;
#(parameter int ranks = 1)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [2:0] request_cmd,
	input wire logic request_valid,
	input wire logic accept,
	input wire logic write_fetch_strobe,
	input wire logic read_valid_out,
	input wire logic read_last_transfer,
	input wire logic refresh_done,
	input wire logic impedance_cal_done,
	input wire logic [ranks-1:0] refresh_cmd_issue,
	input wire logic [ranks-1:0] zq_short_cmd_issue,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Accept answers the strobe of the cycle before; fields lead the strobe
	sequence take_wr;
		$past(request_valid) && accept && $past(request_cmd, 2) == CMD_WRITE;
	endsequence
	sequence take_rd;
		$past(request_valid) && accept && $past(request_cmd, 2) == CMD_READ;
	endsequence
	// Bounds leave room for one transfer of the other kind to drain first
	a_write_fetched: assert property (
		take_wr |-> ##[1:40] write_fetch_strobe) else $error("write not fetched");
	a_read_returned: assert property (
		take_rd |-> ##[1:60] read_valid_out) else $error("read not returned");
	a_reserved_refused: assert property (
		$past(request_valid) && $past(request_cmd, 2) > CMD_READ |-> !accept)
		else $error("bad opcode taken");
	a_avs_one_wait: assert property (
		$rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("no bus answer");
	a_ref_all_ranks: assert property (
		refresh_cmd_issue != '0 |-> refresh_cmd_issue == '1 ##1 refresh_cmd_issue == '0)
		else $error("refresh issue wrong");
	a_zq_all_ranks: assert property (
		zq_short_cmd_issue != '0 |-> zq_short_cmd_issue == '1 ##1 zq_short_cmd_issue == '0)
		else $error("calibration issue wrong");
	a_ref_acked: assert property (
		refresh_cmd_issue != '0 |-> ##[1:12] refresh_done) else $error("refresh not acked");
	a_cal_acked: assert property (
		zq_short_cmd_issue != '0 |-> ##[1:12] impedance_cal_done) else $error("cal not acked");
	a_ack_one_cycle: assert property (
		(refresh_done |=> !refresh_done) and (impedance_cal_done |=> !impedance_cal_done))
		else $error("ack too long");
	a_last_held: assert property (
		read_last_transfer) else $error("last transfer low");
endmodule // dram_ctrl_native_port_assertions

bind dram_ctrl_native_port dram_ctrl_native_port_assertions #(.ranks(ranks)) u_chk (.core_clk,
	.reset, .request_cmd, .request_valid, .accept, .write_fetch_strobe, .read_valid_out,
	.read_last_transfer, .refresh_done, .impedance_cal_done, .refresh_cmd_issue,
	.zq_short_cmd_issue, .avs_read, .avs_write, .avs_waitrequest);

// [tb/user_buffer_model.sv]
`timescale 1ns/1ps
module user_buffer_model
#(parameter int dw = 64, parameter int pw = 4)
(
	input wire logic core_clk,
	input wire logic write_fetch_strobe,
	input wire logic [pw-1:0] write_pointer_echo,
	output logic [dw-1:0] write_payload_in = '0,
	output logic [dw/8-1:0] write_byte_mask_in = '0
);
	logic [dw-1:0] data_q [2**pw];
	logic [dw/8-1:0] mask_q [2**pw];
	// Off-cycle values flip so a late or early sample gives wrong data
	always @(posedge core_clk)
	begin
		if (write_fetch_strobe)
		begin
			write_payload_in <= data_q[write_pointer_echo];
			write_byte_mask_in <= mask_q[write_pointer_echo];
		end
		else
		begin
			write_payload_in <= ~write_payload_in;
			write_byte_mask_in <= ~write_byte_mask_in;
		end
	end
endmodule // user_buffer_model

// [tb/test_dram_ctrl_native_port.sv]
`timescale 1ns/1ps
module test_dram_ctrl_native_port;
	import native_port_pkg::*;
	localparam int dw = 64;
	logic core_clk = 1'b0, reset = 1'b1, auto_precharge_select = 1'b0, request_valid = 1'b0;
	logic refresh_request = 1'b0, impedance_cal_request = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [2:0] request_cmd = '0;
	logic [5:0] request_addr = '0;
	logic [3:0] buffer_pointer_in = '0, write_pointer_echo, read_pointer_echo;
	logic [7:0] avs_address = '0, write_byte_mask_in;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic accept, write_fetch_strobe, read_valid_out, read_last_transfer, refresh_done;
	logic impedance_cal_done, precharge_cmd_issue, avs_waitrequest;
	logic [0:0] refresh_cmd_issue, zq_short_cmd_issue;
	logic [dw-1:0] write_payload_in, read_payload_out, mem [64], rd_q [$];
	logic [3:0] rp_q [$], wp_q [$];
	int n_fail = 0, tests_run = 0, cyc = 0, nref = 0, nzq = 0, nwr = 0;
	dram_ctrl_native_port dut (.core_clk, .reset, .request_cmd, .request_addr, .buffer_pointer_in,
		.auto_precharge_select, .request_valid, .accept, .write_payload_in, .write_byte_mask_in,
		.write_pointer_echo, .write_fetch_strobe, .read_payload_out, .read_pointer_echo,
		.read_valid_out, .read_last_transfer, .self_refresh_request(1'b0),
		.self_refresh_active(), .refresh_request, .refresh_done, .impedance_cal_request,
		.impedance_cal_done, .refresh_cmd_issue, .zq_short_cmd_issue, .precharge_cmd_issue,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	user_buffer_model #(.dw(dw), .pw(4)) user_buf (.core_clk, .write_fetch_strobe,
		.write_pointer_echo, .write_payload_in, .write_byte_mask_in);
	task automatic check(input logic [dw-1:0] seen, input logic [dw-1:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			print_verdict;
		end
		if (!reset && write_fetch_strobe)
			check(write_pointer_echo, wp_q.pop_front());
		if (!reset && read_valid_out)
		begin
			check(read_pointer_echo, rp_q.pop_front());
			check(read_payload_out, rd_q.pop_front());
		end
		nref += refresh_cmd_issue;
		nzq += zq_short_cmd_issue;
	end
	// Fields stay put while retrying, so each strobe names the same request
	task automatic req(input logic [2:0] c, input logic [5:0] a, input logic [3:0] p,
		input logic pc, input int tries, output logic ok);
		@(posedge core_clk);
		request_cmd <= c;
		request_addr <= a;
		buffer_pointer_in <= p;
		auto_precharge_select <= pc;
		@(posedge core_clk);
		ok = 1'b0;
		repeat (tries)
		begin
			request_valid <= 1'b1;
			@(posedge core_clk);
			request_valid <= 1'b0;
			// Accept answers the strobe one cycle later
			@(posedge core_clk);
			ok = (accept === 1'b1);
			if (ok)
				break;
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [3:0] p, input logic pc, input logic full);
		logic [dw-1:0] d;
		logic [7:0] m;
		logic ok;
		d = {$urandom, $urandom};
		m = full ? 8'h00 : 8'($urandom);
		user_buf.data_q[p] = d;
		user_buf.mask_q[p] = m;
		wp_q.push_back(p);
		req(CMD_WRITE, a, p, pc, 50, ok);
		check(ok, 1'b1);
		for (int i = 0; i < 8; i++)
			if (!m[i])
				mem[a][8*i+:8] = d[8*i+:8];
		nwr++;
	endtask
	task automatic rd(input logic [5:0] a, input logic [3:0] p);
		logic ok;
		rp_q.push_back(p);
		rd_q.push_back(mem[a]);
		req(CMD_READ, a, p, 1'b0, 50, ok);
		check(ok, 1'b1);
	endtask
	task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	initial
	begin
		logic [31:0] q;
		logic ok;
		void'($urandom(32'h61a9));
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		avs(1'b0, REG_CONTROL, '0, q);
		check(q, CTRL_RESET);
		avs(1'b0, 8'hfc, '0, q);
		check(q, UNMAPPED_READ);
		for (int i = 0; i < 8; i++)
			wr(6'(i), 4'(i), i[0], 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			wr(6'h30, 4'h0, i[0], 1'b1);
			while (wp_q.size() != 0) @(posedge core_clk);
			repeat (4) @(posedge core_clk);
			avs(1'b0, REG_STATUS, '0, q);
			check(q[STAT_ROW_OPEN_BIT], !i[0]);
		end
		for (int i = 0; i < 24; i++)
			if ($urandom % 2)
				wr(6'($urandom % 8), 4'(i), 1'($urandom), 1'b0);
			else
				rd(6'($urandom % 8), 4'(i));
		avs(1'b1, REG_CONTROL, 32'h1 << CTRL_HOLD_BIT, q);
		req(CMD_READ, '0, '0, 1'b0, 3, ok);
		check(ok, 1'b0);
		avs(1'b1, REG_CONTROL, '0, q);
		for (int c = 2; c < 8; c++)
		begin
			req(3'(c), '0, '0, 1'b0, 3, ok);
			check(ok, 1'b0);
		end
		while (rp_q.size() != 0 || wp_q.size() != 0) @(posedge core_clk);
		@(posedge core_clk);
		refresh_request <= 1'b1;
		impedance_cal_request <= 1'b1;
		@(posedge core_clk);
		refresh_request <= 1'b0;
		impedance_cal_request <= 1'b0;
		repeat (30) @(posedge core_clk);
		check(nref, 1);
		check(nzq, 1);
		avs(1'b0, REG_COUNT, '0, q);
		check(q, nwr);
		print_verdict;
	end
endmodule // test_dram_ctrl_native_port
